// [verilog/output_compare_pwm.sv]
`timescale 1ns/100ps
// Function
// R01: pwm period spans period value plus one
// R02: secondary loads primary at period match only
// R03: primary read-only while pwm selected
// R04: initial primary governs first pwm period
// R05: duty zero keeps output low
// R06: duty above period keeps output high
// R07: duty equal period: low one count
// R08: timebase select picks second or third timer
// R09: codes 111/110 pwm with/without fault
// R10: code 101 low then continuous pulses
// R11: code 100 low then one pulse
// R12: code 011 toggles output on match
// R13: code 010 starts high, match drives low
// R14: code 001 starts low, match drives high
// R15: code 000 disables the channel
// R16: fault flag bit 4, hardware set/clear
// R17: idle stop bit 13 halts in idle
// R18: first fault input channels 1-4, second 5
// R19: unimplemented control bits read zero
// R20: fault reported through compare interrupt flag
// R21: software loads primary before first enable
// R22: software follows fixed pwm start sequence
// R23: pulse modes rise at primary match
// R24: single pulse falls at secondary, stays low
// R25: continuous pulse flags every secondary match
// R26: pwm high at period start, low at duty
// R27: fault forces output low until mode rewrite
module output_compare_pwm
	import compare_pkg::*;
#(
	parameter int unsigned CHANNEL_NUM = 1
) (
	input logic clk, // 100 MHz clock
	input logic rstn, // synchronous reset, active low
	input logic [ADDR_W-1:0] addr, // register byte address
	input logic [DATA_W-1:0] wdata, // write data
	input logic wr, // write strobe
	input logic rd, // read strobe
	output logic [DATA_W-1:0] rdata, // read data, cycle after rd
	input timebase_s timer2_base, // second timer count, period, tick
	input timebase_s timer3_base, // third timer count, period, tick
	input logic cpu_idle, // processor in idle
	input logic fault_input_first_n, // shared fault pin, channels 1-4
	input logic fault_input_second_n, // fault pin, channel 5
	output logic compare_output_pin, // compare output
	output logic compare_irq_flag // one-cycle compare interrupt event
);

	////////////////////////////////////////////////////////////////////
	// state

	control_s ctrl_reg;
	control_s ctrl_next;
	logic [15:0] primary_reg;
	logic [15:0] primary_next;
	logic [15:0] secondary_reg;
	logic [15:0] secondary_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic out_reg;
	logic out_next;
	logic irq_reg;
	logic irq_next;
	pulse_state_e state_reg;
	pulse_state_e state_next;

	////////////////////////////////////////////////////////////////////
	// fault pin synchronisers

	logic [1:0] fault_pin_n;
	logic [1:0] fault_level;
	assign fault_pin_n = {fault_input_second_n, fault_input_first_n};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_fault_sync
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic lvl_reg;
			always_ff @(posedge clk) begin
				if (!rstn) begin
					s1_reg <= 1'h1;
					s2_reg <= 1'h1;
					s3_reg <= 1'h1;
					lvl_reg <= 1'h0;
				end else begin
					s1_reg <= fault_pin_n[gi];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					// a level is accepted only once two stages agree
					if (s2_reg == s3_reg) begin
						lvl_reg <= ~s3_reg;
					end
				end
			end
			assign fault_level[gi] = lvl_reg;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// decode and selection

	wire wr_ctrl = wr && (addr == ADDR_CONTROL);
	wire wr_primary = wr && (addr == ADDR_PRIMARY);
	wire wr_secondary = wr && (addr == ADDR_SECONDARY);
	wire mode_e wmode = mode_e'(wdata[MODE_LSB +: 3]);
	wire mode_e mode = ctrl_reg.mode;
	wire is_pwm = (mode == MODE_PWM) || (mode == MODE_PWM_FAULT); // [R09]
	wire timebase_s tb = ctrl_reg.timebase_sel ? timer3_base : timer2_base; // [R08]
	wire halted = cpu_idle && ctrl_reg.idle_stop; // [R17]
	wire tick = tb.tick && !halted;
	wire period_match = tick && (tb.count == tb.period);
	wire match_primary = tick && (tb.count == primary_reg);
	wire match_secondary = tick && (tb.count == secondary_reg);
	// channels above four listen to the second fault pin
	wire fault_sel = (CHANNEL_NUM <= FIRST_FAULT_LAST_CH) ?
		fault_level[0] : fault_level[1]; // [R18]
	// fault pin ignored in code 110
	wire fault_hit = (mode == MODE_PWM_FAULT) && fault_sel && !wr_ctrl; // [R09] [R27]
	wire fault_lock = (mode == MODE_PWM_FAULT) && ctrl_reg.fault_status;
	// count below duty is high: duty zero never high, duty past period always
	wire pwm_level = tb.count < primary_reg; // [R26] [R05] [R06] [R07]

	wire [15:0] ctrl_read = {2'h0, ctrl_reg.idle_stop, 8'h00, ctrl_reg.fault_status,
		ctrl_reg.timebase_sel, ctrl_reg.mode}; // [R19]
	wire [15:0] read_mux = (addr == ADDR_CONTROL) ? ctrl_read :
		(addr == ADDR_PRIMARY) ? primary_reg :
		(addr == ADDR_SECONDARY) ? secondary_reg : 16'h0000;

	////////////////////////////////////////////////////////////////////
	// register file

	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl) begin
			ctrl_next.idle_stop = wdata[IDLE_STOP_BIT];
			ctrl_next.timebase_sel = wdata[TIMEBASE_BIT];
			ctrl_next.mode = wmode;
			// software cannot write the flag; a mode write ends the fault
			ctrl_next.fault_status = 1'h0; // [R16] [R27]
		end
		if (fault_hit) begin
			ctrl_next.fault_status = 1'h1; // [R16]
		end
	end

	always_comb begin
		primary_next = primary_reg;
		if (is_pwm && period_match) begin
			primary_next = secondary_reg; // [R02]
		end else if (wr_primary && !is_pwm) begin
			primary_next = wdata; // [R03] [R04]
		end
	end

	assign secondary_next = wr_secondary ? wdata : secondary_reg; // [R02]
	assign rdata_next = rd ? read_mux : 16'h0000;

	////////////////////////////////////////////////////////////////////
	// output and pulse sequencing

	always_comb begin
		out_next = out_reg;
		irq_next = 1'h0;
		state_next = state_reg;
		if (wr_ctrl) begin
			state_next = PS_IDLE;
			case (wmode)
				MODE_SET_LOW: out_next = 1'h1; // [R13]
				MODE_TOGGLE: out_next = out_reg;
				MODE_SINGLE, MODE_CONT: begin
					out_next = 1'h0; // [R10] [R11]
					state_next = PS_RISE;
				end
				default: out_next = 1'h0; // [R14] [R15]
			endcase
		end else begin
			case (mode)
				MODE_OFF: out_next = 1'h0; // [R15]
				MODE_SET_HIGH: begin
					if (match_primary) begin
						out_next = 1'h1; // [R14]
						irq_next = 1'h1;
					end
				end
				MODE_SET_LOW: begin
					if (match_primary) begin
						out_next = 1'h0; // [R13]
						irq_next = 1'h1;
					end
				end
				MODE_TOGGLE: begin
					if (match_primary) begin
						out_next = ~out_reg; // [R12]
						irq_next = 1'h1;
					end
				end
				MODE_SINGLE, MODE_CONT: begin
					case (state_reg)
						PS_RISE: begin
							if (match_primary) begin
								out_next = 1'h1; // [R23]
								state_next = PS_FALL;
							end
						end
						PS_FALL: begin
							if (match_secondary) begin
								out_next = 1'h0; // [R24]
								irq_next = 1'h1; // [R25]
								// continuous mode rearms, single mode parks
								state_next = (mode == MODE_CONT) ? PS_RISE : PS_DONE; // [R10] [R24]
							end
						end
						PS_DONE: out_next = 1'h0; // [R24]
						default: state_next = PS_IDLE;
					endcase
				end
				default: begin
					// timer wraps after count equals period: N+1 counts
					if (tick) begin
						out_next = pwm_level; // [R01] [R26]
					end
					if (fault_hit || fault_lock) begin
						out_next = 1'h0; // [R27]
					end
					// report only the onset of a fault
					if (fault_hit && !ctrl_reg.fault_status) begin
						irq_next = 1'h1; // [R20]
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			// field by field, so the register layout of the reset word is kept
			ctrl_reg.idle_stop <= CONTROL_RESET[IDLE_STOP_BIT];
			ctrl_reg.fault_status <= CONTROL_RESET[FAULT_BIT];
			ctrl_reg.timebase_sel <= CONTROL_RESET[TIMEBASE_BIT];
			ctrl_reg.mode <= mode_e'(CONTROL_RESET[MODE_LSB +: 3]);
			primary_reg <= PRIMARY_RESET;
			secondary_reg <= SECONDARY_RESET;
			rdata_reg <= 16'h0000;
			out_reg <= 1'h0;
			irq_reg <= 1'h0;
			state_reg <= PS_IDLE;
		end else begin
			ctrl_reg <= ctrl_next;
			primary_reg <= primary_next;
			secondary_reg <= secondary_next;
			rdata_reg <= rdata_next;
			out_reg <= out_next;
			irq_reg <= irq_next;
			state_reg <= state_next;
		end
	end

	assign rdata = rdata_reg;
	assign compare_output_pin = out_reg;
	assign compare_irq_flag = irq_reg;

	////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	wire pwm_quiet = is_pwm && !wr_ctrl && !fault_hit && !fault_lock;

	property p_duty_zero;
		pwm_quiet && tick && (primary_reg == 16'h0000) |=> !compare_output_pin;
	endproperty
	a_duty_zero: assert property (p_duty_zero) else $error("duty zero drove high"); // [R05]

	property p_duty_full;
		pwm_quiet && tick && (primary_reg > tb.period) |=> compare_output_pin;
	endproperty
	a_duty_full: assert property (p_duty_full) else $error("duty full drove low"); // [R06]

	property p_duty_equal;
		pwm_quiet && period_match && (primary_reg == tb.period) |=> !compare_output_pin;
	endproperty
	a_duty_equal: assert property (p_duty_equal) else $error("duty equal not low"); // [R07]

	property p_transfer;
		is_pwm && period_match |=> primary_reg == $past(secondary_reg);
	endproperty
	a_transfer: assert property (p_transfer) else $error("no duty transfer"); // [R02]

	property p_primary_ro;
		is_pwm && !period_match |=> $stable(primary_reg);
	endproperty
	a_primary_ro: assert property (p_primary_ro) else $error("primary changed in pwm"); // [R03]

	property p_fault_force;
		fault_hit |=> !compare_output_pin && ctrl_reg.fault_status;
	endproperty
	a_fault_force: assert property (p_fault_force) else $error("fault not forced"); // [R27]

	property p_fault_irq;
		fault_hit && !ctrl_reg.fault_status |=> compare_irq_flag ##1 !compare_irq_flag;
	endproperty
	a_fault_irq: assert property (p_fault_irq) else $error("fault not reported"); // [R20]

	property p_reserved;
		rd && (addr == ADDR_CONTROL) |=> (rdata[15:14] == 2'h0) && (rdata[12:5] == 8'h00);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [R19]

	property p_single_done;
		(mode == MODE_SINGLE) && (state_reg == PS_DONE) && !wr_ctrl |=> !compare_output_pin;
	endproperty
	a_single_done: assert property (p_single_done) else $error("second pulse"); // [R24]

	property p_init_low;
		wr_ctrl && (wmode == MODE_SINGLE) |=> !compare_output_pin && (state_reg == PS_RISE);
	endproperty
	a_init_low: assert property (p_init_low) else $error("single not started low"); // [R11]

	property p_halt;
		halted && !wr && !fault_hit && !fault_lock |=> $stable(compare_output_pin);
	endproperty
	a_halt: assert property (p_halt) else $error("output moved in idle"); // [R17]

	c_period: cover property (is_pwm && period_match ##1 compare_output_pin);
	c_fault: cover property (fault_hit ##1 compare_irq_flag);
	c_single: cover property ((mode == MODE_SINGLE) && (state_reg == PS_DONE));
	c_toggle: cover property ((mode == MODE_TOGGLE) && match_primary);

endmodule

// [inc/compare_pkg.sv]
package compare_pkg;

	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;

	// register byte addresses
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_PRIMARY = 4'h4;
	localparam logic [3:0] ADDR_SECONDARY = 4'h8;

	// control field positions
	localparam int unsigned MODE_LSB = 0;
	localparam int unsigned TIMEBASE_BIT = 3;
	localparam int unsigned FAULT_BIT = 4;
	localparam int unsigned IDLE_STOP_BIT = 13;

	// reset values
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] PRIMARY_RESET = 16'h0000;
	localparam logic [15:0] SECONDARY_RESET = 16'h0000;

	// highest channel number served by the first fault input
	localparam int unsigned FIRST_FAULT_LAST_CH = 4;

	typedef enum logic [2:0] {
		MODE_OFF = 3'h0,
		MODE_SET_HIGH = 3'h1,
		MODE_SET_LOW = 3'h2,
		MODE_TOGGLE = 3'h3,
		MODE_SINGLE = 3'h4,
		MODE_CONT = 3'h5,
		MODE_PWM = 3'h6,
		MODE_PWM_FAULT = 3'h7
	} mode_e;

	typedef enum logic [3:0] {
		PS_IDLE = 4'h1,
		PS_RISE = 4'h2,
		PS_FALL = 4'h4,
		PS_DONE = 4'h8
	} pulse_state_e;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] period;
		logic tick;
	} timebase_s;

	typedef struct packed {
		logic idle_stop;
		logic fault_status;
		logic timebase_sel;
		mode_e mode;
	} control_s;

endpackage

// [dv/timer_model.sv]
`timescale 1ns/100ps
module timer_model
	import compare_pkg::*;
#(
	parameter int unsigned DIV = 1
) (
	input wire logic clk, // clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic run, // count enable, low clears the count
	input wire logic [15:0] period, // period match value
	output timebase_s base // count, period and tick to the channel
);
	int unsigned div_reg;
	logic [15:0] count_reg;
	logic tick_reg;
	logic started_reg;

	assign base = '{count: count_reg, period: period, tick: tick_reg};

	////////////////////////////////////////////////////////////////
	// first tick shows count zero, so a fresh start is one full period
	always_ff @(posedge clk) begin
		if (!rstn || !run) begin
			div_reg <= 0;
			count_reg <= 16'h0000;
			tick_reg <= 1'b0;
			started_reg <= 1'b0;
		end else begin
			tick_reg <= (div_reg == DIV - 1);
			div_reg <= (div_reg == DIV - 1) ? 0 : div_reg + 1;
			if (div_reg == DIV - 1) begin
				started_reg <= 1'b1;
				if (started_reg)
					count_reg <= (count_reg == period) ? 16'h0000 : count_reg + 16'h0001;
			end
		end
	end
endmodule

// [dv/output_compare_pwm_tb_top.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module output_compare_pwm_tb_top
	import compare_pkg::*;
;
	logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, cpu_idle = 1'b0, run2 = 1'b0;
	logic flt1_n = 1'b1, flt2_n = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic pin, irq, pin5;
	logic run3 = 1'b0;
	logic [15:0] per2 = 16'h0007, per3 = 16'hffff;
	logic [7:0] h;
	timebase_s t2, t3;
	int bad_count = 0, checked = 0, irqs = 0;
	logic [15:0] ctl_t [8] = '{16'h0001, 16'h0002, 16'h0003, 16'h0000,
		16'h0004, 16'h0005, 16'h2001, 16'h0009};
	logic idl_t [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	logic ini_t [8] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	logic [7:0] h1_t [8] = '{8'h06, 8'h02, 8'h06, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00};
	logic [7:0] h2_t [8] = '{8'h08, 8'h00, 8'h02, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
	int irq_t [8] = '{2, 2, 2, 0, 1, 2, 0, 0};
	logic [15:0] sec_t [3] = '{16'h0000, 16'h0008, 16'h0007};

	always #5 clk = ~clk;
	always @(posedge clk) if (irq === 1'b1) irqs++;

	// slow third timer with a long period never matches during the run
	timer_model #(.DIV(1)) i_t2 (.clk(clk), .rstn(rstn), .run(run2), .period(per2), .base(t2));
	timer_model #(.DIV(3)) i_t3 (.clk(clk), .rstn(rstn), .run(run3), .period(per3), .base(t3));
	output_compare_pwm #(.CHANNEL_NUM(1)) i_dut (.clk(clk), .rstn(rstn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timer2_base(t2), .timer3_base(t3),
		.cpu_idle(cpu_idle), .fault_input_first_n(flt1_n), .fault_input_second_n(flt2_n),
		.compare_output_pin(pin), .compare_irq_flag(irq));
	// fifth channel shares the bus and listens to the second fault pin
	output_compare_pwm #(.CHANNEL_NUM(5)) i_dut5 (.clk(clk), .rstn(rstn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(), .timer2_base(t2), .timer3_base(t3),
		.cpu_idle(cpu_idle), .fault_input_first_n(flt1_n), .fault_input_second_n(flt2_n),
		.compare_output_pin(pin5), .compare_irq_flag());

	////////////////////////////////////////////////////////////////
	task wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask

	// counts high cycles over one period starting at count zero
	task measure(output logic [7:0] hi);
		hi = 8'h00;
		while (!(t2.tick === 1'b1 && t2.count === 16'h0000)) begin
			@(posedge clk);
			#1;
		end
		repeat (8) begin
			@(posedge clk);
			#1 hi = hi + {7'h00, pin};
		end
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	task regs_test;
		rd_chk(ADDR_CONTROL, 16'h0000);
		rd_chk(ADDR_PRIMARY, 16'h0000);
		rd_chk(ADDR_SECONDARY, 16'h0000);
		rd_chk(4'hc, 16'h0000);
		wr_reg(ADDR_CONTROL, 16'hffff);
		rd_chk(ADDR_CONTROL, 16'h200f);
		wr_reg(ADDR_CONTROL, 16'h0000);
		wr_reg(ADDR_PRIMARY, 16'h0002);
		wr_reg(ADDR_SECONDARY, 16'h0005);
	endtask

	task modes_test;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			run2 <= 1'b0;
			cpu_idle <= idl_t[i];
			wr_reg(ADDR_CONTROL, ctl_t[i]);
			repeat (2) @(posedge clk);
			#1 `CHK(pin, ini_t[i])
			irqs = 0;
			@(posedge clk);
			run2 <= 1'b1;
			measure(h);
			`CHK(h, h1_t[i])
			measure(h);
			`CHK(h, h2_t[i])
			`CHK(irqs, irq_t[i])
		end
		cpu_idle <= 1'b0;
	endtask

	task pwm_test;
		@(posedge clk);
		run2 <= 1'b0;
		wr_reg(ADDR_CONTROL, 16'h0000);
		wr_reg(ADDR_SECONDARY, 16'h0005);
		wr_reg(ADDR_PRIMARY, 16'h0003);
		wr_reg(ADDR_CONTROL, 16'h0006);
		wr_reg(ADDR_PRIMARY, 16'h0009);
		rd_chk(ADDR_PRIMARY, 16'h0003);
		@(posedge clk);
		run2 <= 1'b1;
		measure(h);
		`CHK(h, 8'h03)
		measure(h);
		`CHK(h, 8'h05)
		for (int i = 0; i < 3; i++) begin
			wr_reg(ADDR_SECONDARY, sec_t[i]);
			measure(h);
			measure(h);
			`CHK(h, sec_t[i][7:0])
		end
	endtask

	task fault_test;
		wr_reg(ADDR_SECONDARY, 16'h0008);
		wr_reg(ADDR_CONTROL, 16'h0007);
		measure(h);
		measure(h);
		`CHK(h, 8'h08)
		irqs = 0;
		@(posedge clk);
		flt1_n <= 1'b0;
		repeat (6) @(posedge clk);
		#1 `CHK(pin, 1'b0)
		`CHK(pin5, 1'b1)
		rd_chk(ADDR_CONTROL, 16'h0017);
		`CHK(irqs, 1)
		@(posedge clk);
		flt1_n <= 1'b1;
		repeat (6) @(posedge clk);
		rd_chk(ADDR_CONTROL, 16'h0017);
		`CHK(pin, 1'b0)
		wr_reg(ADDR_CONTROL, 16'h0007);
		rd_chk(ADDR_CONTROL, 16'h0007);
		@(posedge clk);
		flt1_n <= 1'b0;
		wr_reg(ADDR_CONTROL, 16'h0006);
		measure(h);
		`CHK(h, 8'h08)
		@(posedge clk);
		flt1_n <= 1'b1;
		flt2_n <= 1'b0;
		// let the released first pin pass its synchroniser before re-arming
		repeat (6) @(posedge clk);
		wr_reg(ADDR_CONTROL, 16'h0007);
		measure(h);
		`CHK(h, 8'h08)
		`CHK(pin5, 1'b0)
		flt2_n <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		run3 <= 1'b1;
		regs_test;
		modes_test;
		pwm_test;
		fault_test;
		close_out;
	end

	initial begin
		#200000;
		bad_count++;
		close_out;
	end
endmodule
